// >>> core/asm_seq_map.svh
// register offsets, field positions, reset values and codes of the sequence mask slice
`ifndef ASM_SEQ_MAP_SVH
`define ASM_SEQ_MAP_SVH
`define ASM_OFF_FB 8'h04
`define ASM_OFF_LO 8'h28
`define ASM_OFF_HI 8'h30
`define ASM_LO_RST 32'h0000_2936
`define ASM_HI_RST 32'h0000_007B
`define ASM_LO9_LSB 0
`define ASM_LO10_LSB 8
`define ASM_HI9_LSB 0
`define ASM_HI10_LSB 4
`define ASM_FB_CHAN_LSB 16
`define ASM_FB_SEQ_LSB 11
`define ASM_FB_ESM_BIT 10
`define ASM_FB_EIM_BIT 9
`define ASM_FB_STOP_BIT 8
`define ASM_SEQ9_IDX 4'h8
`define ASM_SEQ10_IDX 4'h9
`define ASM_CODE_ESM 4'hA
`define ASM_CODE_EMPTY 4'hB
`define ASM_CODE_SUSP 4'hC
`define ASM_CHAN_LOW_LAST 4'h6
`define ASM_CHAN_HIGH_BASE 5'h16
`endif

// >>> core/asm_seq_pkg.sv
// types of the sequence mask and feedback slice
package asm_seq_pkg;
   typedef enum logic [1:0] {
      ASM_IDLE = 2'b00,
      ASM_CONV = 2'b01,
      ASM_WAIT = 2'b10
   } asm_state_e;
endpackage : asm_seq_pkg

// >>> core/asm_seq_regs.sv
// sequence 9/10 channel masks, sequencer feedback and AHB-Lite register slave
`timescale 1ns/1ps
`include "asm_seq_map.svh"

// Summary of operation
// - Sequences nine and ten each have a six-bit mask enabling channels 0-5 in any mix.
// - Sequences nine and ten each have a four-bit protected mask enabling channels 6-9.
// - The low-channel mask word is at 28h and resets to 0000 2936h.
// - The high-channel mask word is at 30h and resets to 0000 007Bh.
// - Feedback bits 20:16 code the converted channel, 0-6 plain and 7-9 as 11101-11111.
// - Feedback bits 14:11 give the active sequence in binary from 0 to 9.
// - The read-only feedback word is at 04h and is cleared by its own reset class.
// - Feedback bits 10 and 9 flag exceptional measurements, bit 8 a stopped sequencer.
// - Feedback bits 3:0 code sequence 1-10, exceptional, empty mask or debug suspend.
module asm_seq_regs (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // async reset, low active
   input wire logic clk_en, // freezes all state when low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   input wire logic wr_prot_open, // protected fields writable
   input wire logic fb_clr, // feedback reset class request
   input wire logic seq_req, // start sequence pulse
   input wire logic [3:0] seq_sel, // sequence index 0..9
   input wire logic [9:0] ext_chan_mask, // mask for sequences 1..8
   input wire logic conv_done, // conversion finished pulse
   input wire logic exc_sequence_busy, // exceptional sequence active
   input wire logic exc_interrupt_meas_busy, // exceptional irq measurement
   input wire logic dbg_suspend, // debug suspend
   output logic conv_start, // start one conversion
   output logic [4:0] conv_chan // coded channel to convert
);

   // ==========================================================
   // helpers
   function automatic logic [4:0] chan_code(input logic [3:0] idx);
      chan_code = (idx <= `ASM_CHAN_LOW_LAST) ? {1'b0, idx}
                                             : 5'({1'b0, idx} + `ASM_CHAN_HIGH_BASE);
   endfunction : chan_code

   function automatic logic [3:0] lowest_set(input logic [9:0] m);
      lowest_set = 4'h0;
      for (int i = 9; i >= 0; i--) begin
         if (m[i]) begin
            lowest_set = 4'(i);
         end
      end
   endfunction : lowest_set

   // ==========================================================
   // bus slave
   logic wr_q, rd_q;
   logic [7:0] addr_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q, hresp_q;
   logic [5:0] lo9_q, lo10_q;
   logic [3:0] hi9_q, hi10_q;

   wire acc = hsel & htrans[1] & hready;
   wire wr_lo = wr_q & hready & (addr_q == `ASM_OFF_LO);
   wire wr_hi = wr_q & hready & (addr_q == `ASM_OFF_HI) & wr_prot_open;
   wire [5:0] lo9_d = wr_lo ? hwdata[`ASM_LO9_LSB +: 6] : lo9_q;
   wire [5:0] lo10_d = wr_lo ? hwdata[`ASM_LO10_LSB +: 6] : lo10_q;
   wire [3:0] hi9_d = wr_hi ? hwdata[`ASM_HI9_LSB +: 4] : hi9_q;
   wire [3:0] hi10_d = wr_hi ? hwdata[`ASM_HI10_LSB +: 4] : hi10_q;

   // ==========================================================
   // sequencer
   asm_seq_pkg::asm_state_e st_q, st_d;
   logic [9:0] pend_q, pend_d;
   logic [3:0] idx_q, idx_d, seq_q, seq_d, code_q, code_d;
   logic [4:0] chan_q, chan_d;
   logic conv_start_q, conv_start_d;

   wire [9:0] sel_mask = (seq_sel == `ASM_SEQ9_IDX) ? {hi9_q, lo9_q}
                       : (seq_sel == `ASM_SEQ10_IDX) ? {hi10_q, lo10_q}
                       : ext_chan_mask;
   wire [3:0] next_idx = lowest_set(pend_q);
   wire [9:0] pend_left = pend_q & ~(10'h001 << idx_q);
   wire stopped = (st_q == asm_seq_pkg::ASM_IDLE);
   wire [3:0] code_fb = dbg_suspend ? `ASM_CODE_SUSP
                      : exc_sequence_busy ? `ASM_CODE_ESM
                      : code_q;
   wire [31:0] fb_word = {11'h000, chan_q, 1'b0, seq_q, exc_sequence_busy,
                          exc_interrupt_meas_busy, stopped, 4'h0, code_fb};
   // forwarded values so a read right after a write sees the new data
   wire [31:0] rd_word = (haddr[7:0] == `ASM_OFF_FB) ? fb_word
                       : (haddr[7:0] == `ASM_OFF_LO) ? {18'h0, lo10_d, 2'h0, lo9_d}
                       : (haddr[7:0] == `ASM_OFF_HI) ? {24'h0, hi10_d, hi9_d}
                       : 32'h0000_0000;

   always_comb begin
      st_d = st_q;
      pend_d = pend_q;
      idx_d = idx_q;
      seq_d = seq_q;
      code_d = code_q;
      chan_d = chan_q;
      conv_start_d = 1'b0;
      unique case (st_q)
         asm_seq_pkg::ASM_IDLE: begin
            if (seq_req) begin
               seq_d = seq_sel;
               if (sel_mask == 10'h000) begin
                  code_d = `ASM_CODE_EMPTY;
               end else begin
                  code_d = seq_sel;
                  pend_d = sel_mask;
                  st_d = asm_seq_pkg::ASM_CONV;
               end
            end
         end
         asm_seq_pkg::ASM_CONV: begin
            // suspend holds the walk before the next conversion is launched
            if (!dbg_suspend) begin
               idx_d = next_idx;
               chan_d = chan_code(next_idx);
               conv_start_d = 1'b1;
               st_d = asm_seq_pkg::ASM_WAIT;
            end
         end
         asm_seq_pkg::ASM_WAIT: begin
            if (conv_done) begin
               pend_d = pend_left;
               st_d = (pend_left == 10'h000) ? asm_seq_pkg::ASM_IDLE
                                             : asm_seq_pkg::ASM_CONV;
            end
         end
         default: begin
            st_d = asm_seq_pkg::ASM_IDLE;
         end
      endcase
   end

   // ==========================================================
   // flip-flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else if (clk_en) begin
         wr_q <= acc & hwrite;
         rd_q <= acc & ~hwrite;
         addr_q <= haddr[7:0];
         if (acc & ~hwrite) begin
            hrdata_q <= rd_word;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lo9_q <= 6'(`ASM_LO_RST >> `ASM_LO9_LSB);
         lo10_q <= 6'(`ASM_LO_RST >> `ASM_LO10_LSB);
         hi9_q <= 4'(`ASM_HI_RST >> `ASM_HI9_LSB);
         hi10_q <= 4'(`ASM_HI_RST >> `ASM_HI10_LSB);
      end else if (clk_en) begin
         lo9_q <= lo9_d;
         lo10_q <= lo10_d;
         hi9_q <= hi9_d;
         hi10_q <= hi10_d;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= asm_seq_pkg::ASM_IDLE;
         pend_q <= 10'h000;
         idx_q <= 4'h0;
         seq_q <= 4'h0;
         code_q <= 4'h0;
         chan_q <= 5'h00;
         conv_start_q <= 1'b0;
      end else if (clk_en) begin
         if (fb_clr) begin
            st_q <= asm_seq_pkg::ASM_IDLE;
            pend_q <= 10'h000;
            idx_q <= 4'h0;
            seq_q <= 4'h0;
            code_q <= 4'h0;
            chan_q <= 5'h00;
            conv_start_q <= 1'b0;
         end else begin
            st_q <= st_d;
            pend_q <= pend_d;
            idx_q <= idx_d;
            seq_q <= seq_d;
            code_q <= code_d;
            chan_q <= chan_d;
            conv_start_q <= conv_start_d;
         end
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign conv_start = conv_start_q;
   assign conv_chan = chan_q;

   // ==========================================================
   // assertions
   property p_lo_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && wr_lo) |=> (lo9_q == $past(hwdata[5:0]) && lo10_q == $past(hwdata[13:8]));
   endproperty
   a_lo_write: assert property (p_lo_write) else $error("low mask write lost");

   property p_hi_prot;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_q && hready && addr_q == `ASM_OFF_HI && !wr_prot_open) |=> $stable({hi10_q, hi9_q});
   endproperty
   a_hi_prot: assert property (p_hi_prot) else $error("protected mask changed");

   property p_rsv_zero;
      @(posedge sys_clk) disable iff (!rst_n)
      rd_q |-> (addr_q != `ASM_OFF_LO || (hrdata_q[31:14] == 18'h0 && hrdata_q[7:6] == 2'h0))
            && (addr_q != `ASM_OFF_HI || hrdata_q[31:8] == 24'h0);
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved mask bits set");

   property p_lo_rst;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> ({lo10_q, lo9_q} == 12'hA76 && {hi10_q, hi9_q} == 8'h7B);
   endproperty
   a_lo_rst: assert property (p_lo_rst) else $error("mask reset value wrong");

   property p_chan_code;
      @(posedge sys_clk) disable iff (!rst_n)
      conv_start_q |-> (conv_chan <= 5'h06 || conv_chan >= 5'h1D);
   endproperty
   a_chan_code: assert property (p_chan_code) else $error("illegal channel code");

   property p_seq_range;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && !fb_clr && stopped && seq_req && seq_sel <= 4'h9) |=> seq_q == $past(seq_sel);
   endproperty
   a_seq_range: assert property (p_seq_range) else $error("active sequence not captured");

   property p_fb_rsv;
      @(posedge sys_clk) disable iff (!rst_n)
      (rd_q && addr_q == `ASM_OFF_FB) |-> (hrdata_q[31:21] == 11'h0 && !hrdata_q[15]
                                        && hrdata_q[7:4] == 4'h0);
   endproperty
   a_fb_rsv: assert property (p_fb_rsv) else $error("feedback reserved bits set");

   property p_stop_bit;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && conv_start_q) |-> ##0 !stopped ##1 (!stopped || $past(conv_done));
   endproperty
   a_stop_bit: assert property (p_stop_bit) else $error("stop flag wrong while running");

   property p_empty;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && !fb_clr && stopped && seq_req && sel_mask == 10'h000)
         |=> (code_q == `ASM_CODE_EMPTY && stopped);
   endproperty
   a_empty: assert property (p_empty) else $error("empty mask not flagged");

   property p_walk;
      @(posedge sys_clk) disable iff (!rst_n)
      conv_start_q |-> (pend_q[idx_q] && (pend_q & ((10'h001 << idx_q) - 10'h001)) == 10'h000);
   endproperty
   a_walk: assert property (p_walk) else $error("converted channel not in mask");

   property p_hi_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && wr_hi) |=> ({hi10_q, hi9_q} == $past(hwdata[7:0]));
   endproperty
   a_hi_write: assert property (p_hi_write) else $error("open protected write lost");

   // read data was captured one edge earlier, so compare with the state seen then
   property p_fb_chan;
      @(posedge sys_clk) disable iff (!rst_n)
      (rd_q && addr_q == `ASM_OFF_FB) |-> (hrdata_q[20:16] == $past(chan_q)
                                        && hrdata_q[14:11] == $past(seq_q));
   endproperty
   a_fb_chan: assert property (p_fb_chan) else $error("feedback channel field wrong");

   property p_conv_pulse;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && conv_start_q) |=> !conv_start_q;
   endproperty
   a_conv_pulse: assert property (p_conv_pulse) else $error("start pulse too long");

   property p_seq_done;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && !fb_clr && st_q == asm_seq_pkg::ASM_WAIT && conv_done && pend_left == 10'h000)
         |=> stopped;
   endproperty
   a_seq_done: assert property (p_seq_done) else $error("sequencer not stopped at end");

   property p_fb_clr;
      @(posedge sys_clk) disable iff (!rst_n)
      (clk_en && fb_clr) |=> (stopped && code_q == 4'h0 && chan_q == 5'h00);
   endproperty
   a_fb_clr: assert property (p_fb_clr) else $error("feedback clear incomplete");

endmodule : asm_seq_regs

// >>> tb/test_adc_sequence_mask_and_feedback.sv
// self-checking bench of the sequence 9/10 mask and feedback register slice
`timescale 1ns/1ps
`include "asm_seq_map.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
   $display("BAD %s expected %h seen %h", nm, exp, got); end end

module test_adc_sequence_mask_and_feedback;
   logic sys_clk, rst_n, clk_en, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic wr_prot_open, fb_clr, seq_req, conv_done, conv_start;
   logic exc_sequence_busy, exc_interrupt_meas_busy, dbg_suspend;
   logic [3:0] seq_sel;
   logic [9:0] ext_chan_mask;
   logic [4:0] conv_chan;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;

   asm_seq_regs asm_seq_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .wr_prot_open(wr_prot_open), .fb_clr(fb_clr), .seq_req(seq_req),
      .seq_sel(seq_sel), .ext_chan_mask(ext_chan_mask), .conv_done(conv_done),
      .exc_sequence_busy(exc_sequence_busy),
      .exc_interrupt_meas_busy(exc_interrupt_meas_busy), .dbg_suspend(dbg_suspend),
      .conv_start(conv_start), .conv_chan(conv_chan));

   // one slave only, so its ready is the bus ready
   assign hready = hreadyout;

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // ==========================================
   // closing and hang guard
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         conclude();
      end
   end

   // ==========================================
   // bus and sequencer tasks
   function automatic logic [4:0] chan_code(input int i);
      return (i < 7) ? 5'(i) : 5'(i + 22);
   endfunction : chan_code

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (hready !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do begin @(posedge sys_clk); n++; end while (hready !== 1'b1 && n < 100);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      bus(1'b1, a, d, dummy);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus(1'b0, a, 32'h00000000, d);
   endtask : rd

   task automatic run_seq(input logic [3:0] sel, input logic [9:0] mask);
      int n;
      logic extra;
      logic [31:0] fb;
      @(posedge sys_clk);
      seq_sel <= sel;
      seq_req <= 1'b1;
      @(posedge sys_clk);
      seq_req <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         if (mask[i]) begin
            n = 0;
            do begin @(posedge sys_clk); #1; n++; end while (conv_start !== 1'b1 && n < 20);
            `CHK("conv start", 1'b1, conv_start)
            `CHK("conv chan", chan_code(i), conv_chan)
            rd(`ASM_OFF_FB, fb);
            `CHK("fb chan", chan_code(i), fb[20:16])
            `CHK("fb active seq", sel, fb[14:11])
            `CHK("fb seq code", sel, fb[3:0])
            `CHK("fb running", 1'b0, fb[8])
            @(posedge sys_clk);
            conv_done <= 1'b1;
            @(posedge sys_clk);
            conv_done <= 1'b0;
         end
      end
      extra = 1'b0;
      repeat (6) begin
         @(posedge sys_clk);
         #1;
         if (conv_start === 1'b1) extra = 1'b1;
      end
      `CHK("no extra start", 1'b0, extra)
      rd(`ASM_OFF_FB, fb);
      `CHK("fb stopped", 1'b1, fb[8])
      if (mask == 10'h000) `CHK("empty code", `ASM_CODE_EMPTY, fb[3:0])
      $display("test sequence %0d done", sel);
   endtask : run_seq

   // ==========================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      wr_prot_open = 1'b0;
      fb_clr = 1'b0;
      seq_req = 1'b0;
      seq_sel = 4'h0;
      ext_chan_mask = 10'h000;
      conv_done = 1'b0;
      exc_sequence_busy = 1'b0;
      exc_interrupt_meas_busy = 1'b0;
      dbg_suspend = 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(`ASM_OFF_LO, v); `CHK("low reset", `ASM_LO_RST, v)
      rd(`ASM_OFF_HI, v); `CHK("high reset", `ASM_HI_RST, v)
      rd(`ASM_OFF_FB, v); `CHK("fb reserved", 32'h00000000, v & 32'hFFE080F0)
      `CHK("bus okay ready", 2'b01, {hresp, hreadyout})
      $display("test reset done");
      wr(`ASM_OFF_LO, 32'hFFFFFFFF); rd(`ASM_OFF_LO, v);
      `CHK("low all ones", 32'h00003F3F, v)
      wr(`ASM_OFF_HI, 32'hFFFFFFFF); rd(`ASM_OFF_HI, v);
      `CHK("high closed", `ASM_HI_RST, v)
      wr_prot_open <= 1'b1;
      wr(`ASM_OFF_HI, 32'hFFFFFFFF); rd(`ASM_OFF_HI, v);
      `CHK("high open", 32'h000000FF, v)
      wr(8'h2C, 32'h00000000); rd(`ASM_OFF_LO, v);
      `CHK("unmapped write", 32'h00003F3F, v)
      wr(`ASM_OFF_FB, 32'hFFFFFFFF); rd(`ASM_OFF_FB, v);
      `CHK("fb write", 32'h00000000, v & 32'hFFE080F0)
      $display("test masks done");
      // channels 0,5,9 for nine and 1-4,6-8 for ten cover every channel code
      wr(`ASM_OFF_LO, 32'h00001E21);
      wr(`ASM_OFF_HI, 32'h00000078);
      run_seq(`ASM_SEQ9_IDX, 10'b1000_100001);
      run_seq(`ASM_SEQ10_IDX, 10'b0111_011110);
      ext_chan_mask <= 10'h004;
      run_seq(4'h2, 10'h004);
      wr(`ASM_OFF_LO, 32'h00000000);
      wr(`ASM_OFF_HI, 32'h00000000);
      run_seq(`ASM_SEQ9_IDX, 10'h000);
      exc_sequence_busy <= 1'b1;
      exc_interrupt_meas_busy <= 1'b1;
      rd(`ASM_OFF_FB, v);
      `CHK("fb exc flags", 2'b11, v[10:9])
      `CHK("fb exc code", `ASM_CODE_ESM, v[3:0])
      exc_sequence_busy <= 1'b0;
      exc_interrupt_meas_busy <= 1'b0;
      dbg_suspend <= 1'b1;
      rd(`ASM_OFF_FB, v);
      `CHK("fb flags off", 2'b00, v[10:9])
      `CHK("fb suspend code", `ASM_CODE_SUSP, v[3:0])
      dbg_suspend <= 1'b0;
      $display("test status done");
      @(posedge sys_clk);
      fb_clr <= 1'b1;
      @(posedge sys_clk);
      fb_clr <= 1'b0;
      rd(`ASM_OFF_LO, v); `CHK("mask kept", 32'h00000000, v)
      rd(`ASM_OFF_FB, v); `CHK("fb cleared", 32'h00000000, v & 32'hFFE080F0)
      `CHK("fb code cleared", 4'h0, v[3:0])
      `CHK("fb stopped after clear", 1'b1, v[8])
      $display("test feedback clear done");
      // a frozen clock enable must swallow the whole write
      clk_en <= 1'b0;
      wr(`ASM_OFF_LO, 32'h00003F3F);
      clk_en <= 1'b1;
      rd(`ASM_OFF_LO, v); `CHK("frozen write", 32'h00000000, v)
      $display("test clock enable done");
      conclude();
   end
endmodule : test_adc_sequence_mask_and_feedback
